//--- trpsm_top.sv
`timescale 1ns/1ps
// Overview of operation
// - bits 7:6 route timer0 ch7: T7/R1/V6/T7
// - bit 5 routes timer0 ch5: T5 or V2
// - bit 4 routes timer0 ch4: T4 or V0
// - bits 3:2 route timer0 ch6: T6/R0/V4/T6
// - bit 1 routes timer1 ch7: T3 or R3
// - bit 0 routes timer1 ch6: T2 or R2
// - routing register read/write anytime, resets zero
// - gpio output drives stored bit; resets zero
// - read gives stored bit if output, else pin
// - pin7: spi select, two-wire data, pulse_width_ch3, gpio
// - pin6: spi clock, pulse_width_ch2, gpio
// - pin5: spi master out, pulse_width_ch1, gpio
// - pin4: spi master in, two-wire clock, pulse_width_ch0, gpio
// - pins 3/2 carry can tx/rx when enabled
// - pin1: serial transmit, pulse_width_ch7, gpio
// - pin0: serial receive, pulse_width_ch6, gpio
// - two-wire on pin7 is open drain, its direction
module trpsm_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire trpsm_pkg::trpsm_axi_req_t axi_req,
   output trpsm_pkg::trpsm_axi_rsp_t axi_rsp,
   input wire trpsm_pkg::trpsm_periph_t periph,
   input wire logic [7:0] ps_pin_in,
   output logic [7:0] ps_pin_out,
   output logic [7:0] ps_pin_oe,
   output logic [7:0] ps_in_sync,
   input wire trpsm_pkg::trpsm_timer_t timer,
   output logic [trpsm_pkg::NUM_CH-1:0] tim_cap_in,
   input wire logic [trpsm_pkg::NUM_TP-1:0] tp_pin_in,
   output logic [trpsm_pkg::NUM_TP-1:0] tp_pin_out,
   output logic [trpsm_pkg::NUM_TP-1:0] tp_pin_oe,
   output logic [trpsm_pkg::NUM_TP-1:0] tp_claim
);
   typedef struct packed {
      logic [7:0] route;
      logic [7:0] data;
      logic [7:0] dir;
      logic aw_ok;
      logic [trpsm_pkg::ADDR_W-1:0] aw_addr;
      logic w_ok;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] ps_s1;
      logic [7:0] ps_s2;
      logic [trpsm_pkg::NUM_TP-1:0] tp_s1;
      logic [trpsm_pkg::NUM_TP-1:0] tp_s2;
      logic [7:0] ps_out;
      logic [7:0] ps_oe;
      logic [trpsm_pkg::NUM_TP-1:0] tp_out;
      logic [trpsm_pkg::NUM_TP-1:0] tp_oe;
      logic [trpsm_pkg::NUM_TP-1:0] tp_claim;
      logic [trpsm_pkg::NUM_CH-1:0] cap;
   } trpsm_state_t;

   trpsm_state_t st_q;
   trpsm_state_t st_d;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;

   // 0 unmapped, 1 routing, 2 data, 3 direction
   function automatic logic [1:0] reg_decode(input logic [trpsm_pkg::ADDR_W-1:0] a);
      if (a == trpsm_pkg::ADDR_ROUTE) begin
         return 2'h1;
      end else if (a == trpsm_pkg::ADDR_DATA) begin
         return 2'h2;
      end else if (a == trpsm_pkg::ADDR_DIR) begin
         return 2'h3;
      end else begin
         return 2'h0;
      end
   endfunction : reg_decode

   // pin index chosen for a timer channel by the routing register
   function automatic logic [3:0] route_pin(input int unsigned ch, input logic [7:0] r);
      logic [3:0] p;
      logic [1:0] s7;
      logic [1:0] s6;
      p = trpsm_pkg::P_T7;
      s7 = r[trpsm_pkg::F_T0C7_HI:trpsm_pkg::F_T0C7_LO];
      s6 = r[trpsm_pkg::F_T0C6_HI:trpsm_pkg::F_T0C6_LO];
      case (ch)
         trpsm_pkg::CH_T0C7: begin
            if (s7 == trpsm_pkg::SEL_ALT_R) begin
               p = trpsm_pkg::P_R1;
            end else if (s7 == trpsm_pkg::SEL_ALT_V) begin
               p = trpsm_pkg::P_V6;
            end else begin
               p = trpsm_pkg::P_T7;
            end
         end
         trpsm_pkg::CH_T0C6: begin
            if (s6 == trpsm_pkg::SEL_ALT_R) begin
               p = trpsm_pkg::P_R0;
            end else if (s6 == trpsm_pkg::SEL_ALT_V) begin
               p = trpsm_pkg::P_V4;
            end else begin
               p = trpsm_pkg::P_T6;
            end
         end
         trpsm_pkg::CH_T0C5: p = r[trpsm_pkg::F_T0C5] ? trpsm_pkg::P_V2 : trpsm_pkg::P_T5;
         trpsm_pkg::CH_T0C4: p = r[trpsm_pkg::F_T0C4] ? trpsm_pkg::P_V0 : trpsm_pkg::P_T4;
         trpsm_pkg::CH_T1C7: p = r[trpsm_pkg::F_T1C7] ? trpsm_pkg::P_R3 : trpsm_pkg::P_T3;
         default: p = r[trpsm_pkg::F_T1C6] ? trpsm_pkg::P_R2 : trpsm_pkg::P_T2;
      endcase
      return p;
   endfunction : route_pin

   assign aw_hs = axi_req.awvalid && axi_rsp.awready;
   assign w_hs = axi_req.wvalid && axi_rsp.wready;
   assign ar_hs = axi_req.arvalid && axi_rsp.arready;

   always_comb begin
      logic [3:0] pi;
      logic [7:0] rd;
      pi = 4'h0;
      rd = 8'h00;
      st_d = st_q;
      // only the second stage is read by logic
      st_d.ps_s1 = ps_pin_in;
      st_d.ps_s2 = st_q.ps_s1;
      st_d.tp_s1 = tp_pin_in;
      st_d.tp_s2 = st_q.tp_s1;
      // write channel: address and data taken in either order
      if (aw_hs) begin
         st_d.aw_ok = 1'b1;
         st_d.aw_addr = axi_req.awaddr;
      end
      if (w_hs) begin
         st_d.w_ok = 1'b1;
         st_d.w_data = axi_req.wdata[7:0];
         st_d.w_lane0 = axi_req.wstrb[0];
      end
      if (st_q.aw_ok && st_q.w_ok) begin
         st_d.aw_ok = 1'b0;
         st_d.w_ok = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = trpsm_pkg::RESP_OKAY;
         case (reg_decode(st_q.aw_addr))
            2'h1: if (st_q.w_lane0) st_d.route = st_q.w_data;
            2'h2: if (st_q.w_lane0) st_d.data = st_q.w_data;
            2'h3: if (st_q.w_lane0) st_d.dir = st_q.w_data;
            default: st_d.bresp = trpsm_pkg::RESP_SLVERR;
         endcase
      end
      if (st_q.bvalid && axi_req.bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.rvalid && axi_req.rready) begin
         st_d.rvalid = 1'b0;
      end
      if (ar_hs) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = trpsm_pkg::RESP_OKAY;
         case (reg_decode(axi_req.araddr))
            2'h1: rd = st_q.route;
            2'h2: rd = (st_q.dir & st_q.data) | (~st_q.dir & st_q.ps_s2);
            2'h3: rd = st_q.dir;
            default: st_d.rresp = trpsm_pkg::RESP_SLVERR;
         endcase
         st_d.rdata = rd;
      end
      // timer routing; unselected candidates stay released
      st_d.tp_claim = '0;
      st_d.tp_out = '0;
      st_d.tp_oe = '0;
      for (int unsigned ch = 0; ch < trpsm_pkg::NUM_CH; ch++) begin
         pi = route_pin(ch, st_q.route);
         st_d.tp_claim[pi] = 1'b1;
         st_d.tp_out[pi] = timer.tim_out[ch];
         st_d.tp_oe[pi] = timer.tim_oe[ch];
         st_d.cap[ch] = st_q.tp_s2[pi];
      end
      // port S: gpio by default, peripherals override by priority
      st_d.ps_out = st_q.data;
      st_d.ps_oe = st_q.dir;
      if (periph.spi_en) begin
         st_d.ps_out[7] = periph.spi_out[3];
         st_d.ps_oe[7] = periph.spi_oe[3];
      end else if (periph.iic_en) begin
         // open drain: only ever pulls low
         st_d.ps_out[7] = 1'b0;
         st_d.ps_oe[7] = periph.iic_oe[1] && !periph.iic_out[1];
      end else if (periph.pwm_en[3]) begin
         st_d.ps_out[7] = periph.pwm_out[3];
         st_d.ps_oe[7] = 1'b1;
      end
      if (periph.spi_en) begin
         st_d.ps_out[6] = periph.spi_out[2];
         st_d.ps_oe[6] = periph.spi_oe[2];
      end else if (periph.pwm_en[2]) begin
         st_d.ps_out[6] = periph.pwm_out[2];
         st_d.ps_oe[6] = 1'b1;
      end
      if (periph.spi_en) begin
         st_d.ps_out[5] = periph.spi_out[1];
         st_d.ps_oe[5] = periph.spi_oe[1];
      end else if (periph.pwm_en[1]) begin
         st_d.ps_out[5] = periph.pwm_out[1];
         st_d.ps_oe[5] = 1'b1;
      end
      if (periph.spi_en) begin
         st_d.ps_out[4] = periph.spi_out[0];
         st_d.ps_oe[4] = periph.spi_oe[0];
      end else if (periph.iic_en) begin
         st_d.ps_out[4] = 1'b0;
         st_d.ps_oe[4] = periph.iic_oe[0] && !periph.iic_out[0];
      end else if (periph.pwm_en[0]) begin
         st_d.ps_out[4] = periph.pwm_out[0];
         st_d.ps_oe[4] = 1'b1;
      end
      if (periph.can_en) begin
         st_d.ps_out[3] = periph.can_tx;
         st_d.ps_oe[3] = 1'b1;
         st_d.ps_out[2] = 1'b0;
         st_d.ps_oe[2] = 1'b0;
      end
      if (periph.sci_en) begin
         st_d.ps_out[1] = periph.sci_tx;
         st_d.ps_oe[1] = 1'b1;
      end else if (periph.pwm_en[7]) begin
         st_d.ps_out[1] = periph.pwm_out[7];
         st_d.ps_oe[1] = 1'b1;
      end
      if (periph.sci_en) begin
         st_d.ps_out[0] = 1'b0;
         st_d.ps_oe[0] = 1'b0;
      end else if (periph.pwm_en[6]) begin
         st_d.ps_out[0] = periph.pwm_out[6];
         st_d.ps_oe[0] = 1'b1;
      end
      if (!aresetn) begin
         st_d = '0;
         st_d.route = trpsm_pkg::RST_ROUTE;
         st_d.data = trpsm_pkg::RST_DATA;
         st_d.dir = trpsm_pkg::RST_DIR;
      end
   end

   always_ff @(posedge aclk) begin
      st_q <= st_d;
   end

   // no new write is taken while a response waits, so one write at a time
   assign axi_rsp.awready = !st_q.aw_ok && !st_q.bvalid;
   assign axi_rsp.wready = !st_q.w_ok && !st_q.bvalid;
   assign axi_rsp.bvalid = st_q.bvalid;
   assign axi_rsp.bresp = st_q.bresp;
   assign axi_rsp.arready = !st_q.rvalid;
   assign axi_rsp.rvalid = st_q.rvalid;
   assign axi_rsp.rdata = {24'h000000, st_q.rdata};
   assign axi_rsp.rresp = st_q.rresp;
   assign ps_pin_out = st_q.ps_out;
   assign ps_pin_oe = st_q.ps_oe;
   assign ps_in_sync = st_q.ps_s2;
   assign tim_cap_in = st_q.cap;
   assign tp_pin_out = st_q.tp_out;
   assign tp_pin_oe = st_q.tp_oe;
   assign tp_claim = st_q.tp_claim;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_t0c7_route: assert property ($past(aresetn) && $past(st_q.route[7:6]) == 2'h2 |->
      tp_claim[trpsm_pkg::P_V6] && !tp_claim[trpsm_pkg::P_T7] && !tp_claim[trpsm_pkg::P_R1])
      else $error("timer0 ch7 not on port V pin 6");
   a_t0c7_resvd: assert property ($past(aresetn) && $past(st_q.route[7:6]) == 2'h3 |->
      tp_claim[trpsm_pkg::P_T7] && !tp_claim[trpsm_pkg::P_V6])
      else $error("reserved code does not keep port T pin 7");
   a_t0c5_route: assert property ($past(aresetn) |->
      tp_claim[trpsm_pkg::P_V2] == $past(st_q.route[5])
      && tp_claim[trpsm_pkg::P_T5] != tp_claim[trpsm_pkg::P_V2])
      else $error("timer0 ch5 routing wrong");
   a_t0c4_route: assert property ($past(aresetn) && $past(st_q.route[4]) |->
      tp_pin_oe[trpsm_pkg::P_V0] == $past(timer.tim_oe[trpsm_pkg::CH_T0C4])
      && !tp_claim[trpsm_pkg::P_T4])
      else $error("timer0 ch4 routing wrong");
   a_t0c6_route: assert property ($past(aresetn) && $past(st_q.route[3:2]) == 2'h1 |->
      tp_pin_out[trpsm_pkg::P_R0] == $past(timer.tim_out[trpsm_pkg::CH_T0C6]))
      else $error("timer0 ch6 not on port R pin 0");
   a_t1c7_route: assert property ($past(aresetn) && $past(st_q.route[1]) |->
      tim_cap_in[trpsm_pkg::CH_T1C7] == $past(st_q.tp_s2[trpsm_pkg::P_R3]))
      else $error("timer1 ch7 capture not from port R pin 3");
   a_t1c6_route: assert property ($past(aresetn) && !$past(st_q.route[0]) |->
      tp_claim[trpsm_pkg::P_T2] && !tp_claim[trpsm_pkg::P_R2])
      else $error("timer1 ch6 not on port T pin 2");
   a_route_reset: assert property (@(posedge aclk) disable iff (1'b0) !$past(aresetn) |->
      st_q.route == 8'h00 && st_q.data == 8'h00)
      else $error("registers not cleared by reset");
   a_gpio_drive: assert property ($past(aresetn) && !$past(periph.can_en) |->
      ps_pin_out[3] == $past(st_q.data[3]) && ps_pin_oe[3] == $past(st_q.dir[3]))
      else $error("gpio pin 3 not driven from data");
   a_read_data: assert property (ar_hs && axi_req.araddr == trpsm_pkg::ADDR_DATA |=>
      axi_rsp.rvalid && axi_rsp.rdata[7:0] == (($past(st_q.dir) & $past(st_q.data))
      | (~$past(st_q.dir) & $past(st_q.ps_s2))))
      else $error("port S data read source wrong");
   a_pin7_spi: assert property ($past(aresetn) && $past(periph.spi_en) |->
      ps_pin_out[7] == $past(periph.spi_out[3]) && ps_pin_oe[7] == $past(periph.spi_oe[3]))
      else $error("pin 7 not owned by spi");
   a_pin6_pwm: assert property ($past(aresetn) && !$past(periph.spi_en)
      && $past(periph.pwm_en[2]) |-> ps_pin_oe[6] && ps_pin_out[6] == $past(periph.pwm_out[2]))
      else $error("pin 6 not owned by pulse_width_ch2");
   a_pin5_spi: assert property ($past(aresetn) && $past(periph.spi_en) |->
      ps_pin_oe[5] == $past(periph.spi_oe[1]))
      else $error("pin 5 not owned by spi");
   a_pin4_iic: assert property ($past(aresetn) && !$past(periph.spi_en)
      && $past(periph.iic_en) |-> !ps_pin_out[4]
      && ps_pin_oe[4] == ($past(periph.iic_oe[0]) && !$past(periph.iic_out[0])))
      else $error("pin 4 not owned by two-wire clock");
   a_can_pins: assert property ($past(aresetn) && $past(periph.can_en) |->
      ps_pin_oe[3] && ps_pin_out[3] == $past(periph.can_tx) && !ps_pin_oe[2])
      else $error("can pins wrong");
   a_pin1_sci: assert property ($past(aresetn) && $past(periph.sci_en) |->
      ps_pin_oe[1] && ps_pin_out[1] == $past(periph.sci_tx))
      else $error("pin 1 not owned by serial transmit");
   a_pin0_sci: assert property ($past(aresetn) && $past(periph.sci_en) |-> !ps_pin_oe[0])
      else $error("pin 0 driven while serial receive owns it");
   a_iic_odrain: assert property ($past(aresetn) && !$past(periph.spi_en)
      && $past(periph.iic_en)
      |-> !ps_pin_out[7] && ps_pin_oe[7] == ($past(periph.iic_oe[1]) && !$past(periph.iic_out[1])))
      else $error("two-wire pin 7 not open drain");
   a_unrouted_off: assert property ((~tp_claim & tp_pin_oe) == '0)
      else $error("unrouted timer pin still driven");
endmodule : trpsm_top

//--- trpsm_pkg.sv
package trpsm_pkg;
   localparam int unsigned ADDR_W = 12;
   // printed offsets are register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_ROUTE = 12'h247;
   localparam logic [ADDR_W-1:0] IDX_DATA = 12'h248;
   localparam logic [ADDR_W-1:0] IDX_DIR = 12'h24a;
   localparam logic [ADDR_W-1:0] ADDR_ROUTE = 12'(IDX_ROUTE * 4);
   localparam logic [ADDR_W-1:0] ADDR_DATA = 12'(IDX_DATA * 4);
   localparam logic [ADDR_W-1:0] ADDR_DIR = 12'(IDX_DIR * 4);
   localparam logic [7:0] RST_ROUTE = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // routing field positions
   localparam int unsigned F_T0C7_HI = 7;
   localparam int unsigned F_T0C7_LO = 6;
   localparam int unsigned F_T0C5 = 5;
   localparam int unsigned F_T0C4 = 4;
   localparam int unsigned F_T0C6_HI = 3;
   localparam int unsigned F_T0C6_LO = 2;
   localparam int unsigned F_T1C7 = 1;
   localparam int unsigned F_T1C6 = 0;
   localparam logic [1:0] SEL_ALT_R = 2'h1;
   localparam logic [1:0] SEL_ALT_V = 2'h2;
   // timer channel order on the timer ports
   localparam int unsigned CH_T0C7 = 0;
   localparam int unsigned CH_T0C6 = 1;
   localparam int unsigned CH_T0C5 = 2;
   localparam int unsigned CH_T0C4 = 3;
   localparam int unsigned CH_T1C7 = 4;
   localparam int unsigned CH_T1C6 = 5;
   localparam int unsigned NUM_CH = 6;
   // candidate timer pin order on the timer pin ports
   localparam logic [3:0] P_T2 = 4'h0;
   localparam logic [3:0] P_T3 = 4'h1;
   localparam logic [3:0] P_T4 = 4'h2;
   localparam logic [3:0] P_T5 = 4'h3;
   localparam logic [3:0] P_T6 = 4'h4;
   localparam logic [3:0] P_T7 = 4'h5;
   localparam logic [3:0] P_R0 = 4'h6;
   localparam logic [3:0] P_R1 = 4'h7;
   localparam logic [3:0] P_R2 = 4'h8;
   localparam logic [3:0] P_R3 = 4'h9;
   localparam logic [3:0] P_V0 = 4'ha;
   localparam logic [3:0] P_V2 = 4'hb;
   localparam logic [3:0] P_V4 = 4'hc;
   localparam logic [3:0] P_V6 = 4'hd;
   localparam int unsigned NUM_TP = 14;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } trpsm_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } trpsm_axi_rsp_t;

   // spi bits: 3 slave select, 2 clock, 1 master out, 0 master in
   // two wire bits: 1 data, 0 clock
   typedef struct packed {
      logic spi_en;
      logic [3:0] spi_out;
      logic [3:0] spi_oe;
      logic iic_en;
      logic [1:0] iic_out;
      logic [1:0] iic_oe;
      logic [7:0] pwm_en;
      logic [7:0] pwm_out;
      logic can_en;
      logic can_tx;
      logic sci_en;
      logic sci_tx;
   } trpsm_periph_t;

   typedef struct packed {
      logic [NUM_CH-1:0] tim_out;
      logic [NUM_CH-1:0] tim_oe;
   } trpsm_timer_t;
endpackage : trpsm_pkg

//--- trpsm_pins.sv
`timescale 1ns/1ps
// external pin model: a driven pin shows its drive, a released pin shows
// the level the bench puts on the board, never the last driven value
module trpsm_pins (
   input wire logic [7:0] ps_out,
   input wire logic [7:0] ps_oe,
   input wire logic [7:0] ext_ps,
   input wire logic [13:0] tp_out,
   input wire logic [13:0] tp_oe,
   input wire logic [13:0] ext_tp,
   output logic [7:0] ps_lvl,
   output logic [13:0] tp_lvl
);
   assign ps_lvl = (ps_oe & ps_out) | (~ps_oe & ext_ps);
   assign tp_lvl = (tp_oe & tp_out) | (~tp_oe & ext_tp);
endmodule : trpsm_pins

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   logic aclk;
   logic aresetn;
   trpsm_pkg::trpsm_axi_req_t req;
   trpsm_pkg::trpsm_axi_rsp_t rsp;
   trpsm_pkg::trpsm_periph_t per;
   trpsm_pkg::trpsm_timer_t tim;
   logic [7:0] ext_ps, ps_in, ps_out, ps_oe, ps_sync;
   logic [3:0] strb;
   logic [13:0] ext_tp, tp_in, tp_out, tp_oe, claim, ecl, eout;
   logic [5:0] cap, ecap;
   logic [31:0] rdv;
   logic [1:0] resp;
   int err_total;
   int tests_run;
   int cyc;
   logic [7:0] rv[4] = '{8'h00, 8'h55, 8'haa, 8'hff};

   trpsm_top trpsm_top_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .periph(per), .ps_pin_in(ps_in), .ps_pin_out(ps_out), .ps_pin_oe(ps_oe),
      .ps_in_sync(ps_sync), .timer(tim), .tim_cap_in(cap), .tp_pin_in(tp_in),
      .tp_pin_out(tp_out), .tp_pin_oe(tp_oe), .tp_claim(claim));
   trpsm_pins trpsm_pins_i (.ps_out(ps_out), .ps_oe(ps_oe), .ext_ps(ext_ps),
      .tp_out(tp_out), .tp_oe(tp_oe), .ext_tp(ext_tp), .ps_lvl(ps_in), .tp_lvl(tp_in));

   initial begin
      aclk = 1'h0;
      forever #20 aclk = ~aclk;
   end

   task automatic complete_run;
      $display("mismatches %0d of %0d comparisons", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   // run takes under two hundred cycles; far above that means a hang
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // each channel held until its own edge; sampled mid-cycle to avoid races
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic ta, tw, got;
      got = 1'h0;
      @(posedge aclk);
      req.awvalid <= 1'h1;
      req.awaddr <= a;
      req.wvalid <= 1'h1;
      req.wdata <= {24'h0, d};
      req.wstrb <= strb;
      req.bready <= 1'h1;
      while (!got) begin
         @(negedge aclk);
         ta = req.awvalid & rsp.awready;
         tw = req.wvalid & rsp.wready;
         got = rsp.bvalid;
         resp = rsp.bresp;
         @(posedge aclk);
         if (ta) req.awvalid <= 1'h0;
         if (tw) req.wvalid <= 1'h0;
      end
      req.bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      logic ta, got;
      got = 1'h0;
      @(posedge aclk);
      req.arvalid <= 1'h1;
      req.araddr <= a;
      req.rready <= 1'h1;
      while (!got) begin
         @(negedge aclk);
         ta = req.arvalid & rsp.arready;
         got = rsp.rvalid;
         rdv = rsp.rdata;
         resp = rsp.rresp;
         @(posedge aclk);
         if (ta) req.arvalid <= 1'h0;
      end
      req.rready <= 1'h0;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : settle

   task automatic pchk(input logic [7:0] eo, input logic [7:0] eoe);
      settle(2);
      chk({24'h0, ps_out & ps_oe}, {24'h0, eo});
      chk({24'h0, ps_oe}, {24'h0, eoe});
      @(posedge aclk);
   endtask : pchk

   function automatic int pin_of(input logic [7:0] r, input int ch);
      case (ch)
         0: return r[7:6] == 2'h1 ? 7 : (r[7:6] == 2'h2 ? 13 : 5);
         1: return r[3:2] == 2'h1 ? 6 : (r[3:2] == 2'h2 ? 12 : 4);
         2: return r[5] ? 11 : 3;
         3: return r[4] ? 10 : 2;
         4: return r[1] ? 9 : 1;
         default: return r[0] ? 8 : 0;
      endcase
   endfunction : pin_of

   initial begin
      req = '0;
      per = '0;
      tim = '0;
      ext_ps = 8'hc3;
      ext_tp = 14'h2b6d;
      aresetn = 1'h0;
      err_total = 0;
      tests_run = 0;
      cyc = 0;
      strb = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      rd(trpsm_pkg::ADDR_ROUTE);
      chk(rdv, 32'h0);
      chk({30'h0, resp}, {30'h0, trpsm_pkg::RESP_OKAY});
      rd(trpsm_pkg::ADDR_DIR);
      chk(rdv, 32'h0);
      rd(12'h000);
      chk({30'h0, resp}, {30'h0, trpsm_pkg::RESP_SLVERR});
      wr(12'h004, 8'hff);
      chk({30'h0, resp}, {30'h0, trpsm_pkg::RESP_SLVERR});
      // every code of every routing field, reserved codes included
      foreach (rv[i]) begin
         wr(trpsm_pkg::ADDR_ROUTE, rv[i]);
         rd(trpsm_pkg::ADDR_ROUTE);
         chk(rdv, {24'h0, rv[i]});
         tim.tim_oe <= 6'h3f;
         tim.tim_out <= 6'h2d;
         settle(2);
         ecl = '0;
         eout = '0;
         for (int c = 0; c < 6; c++) begin
            ecl[pin_of(rv[i], c)] = 1'h1;
            eout[pin_of(rv[i], c)] = tim.tim_out[c];
            ecap[c] = ext_tp[pin_of(rv[i], c)];
         end
         chk({18'h0, claim}, {18'h0, ecl});
         chk({18'h0, tp_oe}, {18'h0, ecl});
         chk({18'h0, tp_out & ecl}, {18'h0, eout});
         @(posedge aclk);
         tim.tim_oe <= 6'h00;
         settle(4);
         chk({26'h0, cap}, {26'h0, ecap});
      end
      wr(trpsm_pkg::ADDR_DIR, 8'hff);
      chk({30'h0, resp}, {30'h0, trpsm_pkg::RESP_OKAY});
      rd(trpsm_pkg::ADDR_DATA);
      chk(rdv, 32'h0);
      wr(trpsm_pkg::ADDR_DATA, 8'h5a);
      pchk(8'h5a, 8'hff);
      rd(trpsm_pkg::ADDR_DATA);
      chk(rdv, 32'h5a);
      // byte lane 0 off: the write is answered but must not land
      strb = 4'h0;
      wr(trpsm_pkg::ADDR_DATA, 8'h33);
      strb = 4'hf;
      chk({30'h0, resp}, {30'h0, trpsm_pkg::RESP_OKAY});
      rd(trpsm_pkg::ADDR_DATA);
      chk(rdv, 32'h5a);
      wr(trpsm_pkg::ADDR_DIR, 8'h0f);
      settle(4);
      chk({24'h0, ps_sync}, 32'hca);
      rd(trpsm_pkg::ADDR_DATA);
      chk(rdv, 32'hca);
      // gpio drives 1 on pins 3 and 2 so overrides show there
      wr(trpsm_pkg::ADDR_DIR, 8'hff);
      wr(trpsm_pkg::ADDR_DATA, 8'h0c);
      per.pwm_en <= 8'hff;
      per.pwm_out <= 8'hff;
      pchk(8'hff, 8'hff);
      per.iic_en <= 1'h1;
      per.iic_out <= 2'h2;
      per.iic_oe <= 2'h3;
      pchk(8'h6f, 8'h7f);
      per.spi_en <= 1'h1;
      per.spi_out <= 4'ha;
      per.spi_oe <= 4'h6;
      pchk(8'h2f, 8'h6f);
      per.can_en <= 1'h1;
      per.sci_en <= 1'h1;
      per.sci_tx <= 1'h1;
      pchk(8'h22, 8'h6a);
      per <= '0;
      pchk(8'h0c, 8'hff);
      // mid-run reset must clear routing and data again
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(trpsm_pkg::ADDR_ROUTE);
      chk(rdv, 32'h0);
      wr(trpsm_pkg::ADDR_DIR, 8'hff);
      pchk(8'h00, 8'hff);
      complete_run();
   end
endmodule : testbench
